// ---- design/pmes_defines.vh ----
// Constants for the performance monitor event select slice
`ifndef PMES_DEFINES_VH
`define PMES_DEFINES_VH

`define PMES_SPR_CNT1      10'h3B9
`define PMES_SPR_CNT2      10'h3BA
`define PMES_SPR_SIA       10'h3BB
`define PMES_SPR_CNT3      10'h3BD
`define PMES_SPR_CNT4      10'h3BE
`define PMES_SPR_SDA       10'h3BF
`define PMES_SPR_UCNT1     10'h3A9
`define PMES_SPR_UCNT2     10'h3AA
`define PMES_SPR_USER_SAMPLED_INSTR_MIRROR      10'h3AB
`define PMES_SPR_UCNT3     10'h3AD
`define PMES_SPR_UCNT4     10'h3AE
`define PMES_SPR_USER_SAMPLED_DATA_UNUSED      10'h3AF

`define PMES_SEL3_HI       31
`define PMES_SEL3_LO       27
`define PMES_SEL4_HI       26
`define PMES_SEL4_LO       22

`define PMES_TB_BIT47      16
`define PMES_TB_BIT51      12
`define PMES_TB_BIT55      8
`define PMES_TB_BIT63      0

`define PMES_EV_HOLD       5'h00
`define PMES_EV_CYCLE      5'h01
`define PMES_EV_CMPL       5'h02
`define PMES_EV_TB         5'h03
`define PMES_EV_DISP       5'h04
`define PMES_EV3_MAX       5'h11
`define PMES_EV3_RSVD      5'h0E
`define PMES_EV4_MAX       5'h0E
`define PMES_EV4_RSVD      5'h07

`define PMES_CNT_TOP       31
`define PMES_RESET_VAL     32'h0000_0000

`endif

// ---- design/pmes_core.v ----
// Performance monitor counters, event select and sampled address
`include "pmes_defines.vh"

module pmes_core (
    input  wire        clk,
    input  wire        resetn,
    input  wire        ce,
    // Special register move port
    input  wire        spr_wr,
    input  wire        spr_rd,
    input  wire [9:0]  spr_num,
    input  wire [31:0] spr_wdata,
    output reg  [31:0] spr_rdata,
    output reg         spr_rvalid,
    output wire        spr_hit,
    // Monitor control
    input  wire [31:0] monitor_control_second,
    input  wire [1:0]  timebase_bit_select,
    input  wire [3:0]  counter_irq_control,
    input  wire        global_irq_enable,
    input  wire        stop_on_irq,
    // Event sources
    input  wire [1:0]  cnt1_inc,
    input  wire [1:0]  cnt2_inc,
    input  wire        instr_cmpl,
    input  wire [1:0]  instr_disp,
    input  wire [31:0] timebase_lower,
    input  wire [17:5] cnt3_events,
    input  wire [14:5] cnt4_events,
    input  wire        threshold_event,
    input  wire [31:0] threshold_iaddr,
    input  wire [31:0] last_cmpl_iaddr,
    output wire        pm_irq
);

    // ************************************************************
    // Event decoding
    // ************************************************************

    // Amount added to a counter this cycle for one select code
    function [1:0] ev_amount;
        input [4:0]  sel;
        input [31:0] evs;
        input        cmpl;
        input [1:0]  disp;
        input        tb_rise;
        input [4:0]  max_code;
        input [4:0]  rsvd_code;
        begin
            ev_amount = 2'h0;
            case (sel)
                `PMES_EV_HOLD:  ev_amount = 2'h0;
                `PMES_EV_CYCLE: ev_amount = 2'h1;
                `PMES_EV_CMPL:  ev_amount = {1'b0, cmpl};
                `PMES_EV_TB:    ev_amount = {1'b0, tb_rise};
                `PMES_EV_DISP:  ev_amount = disp;
                default: begin
                    if (sel <= max_code && sel != rsvd_code)
                        ev_amount = {1'b0, evs[sel]};
                    else
                        ev_amount = 2'h0;
                end
            endcase
        end
    endfunction

    wire [4:0] sel3 = monitor_control_second[`PMES_SEL3_HI:`PMES_SEL3_LO];
    wire [4:0] sel4 = monitor_control_second[`PMES_SEL4_HI:`PMES_SEL4_LO];

    // ************************************************************
    // Time base bit edge detection
    // ************************************************************

    reg tb_bit;
    reg tb_prev_r;

    always @* begin
        case (timebase_bit_select)
            2'h0:    tb_bit = timebase_lower[`PMES_TB_BIT47];
            2'h1:    tb_bit = timebase_lower[`PMES_TB_BIT51];
            2'h2:    tb_bit = timebase_lower[`PMES_TB_BIT55];
            default: tb_bit = timebase_lower[`PMES_TB_BIT63];
        endcase
    end

    wire tb_rise = tb_bit & ~tb_prev_r;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tb_prev_r <= 1'b0;
        end else if (ce) begin
            tb_prev_r <= tb_bit;
        end
    end

    // Event vectors indexed by select code; unused positions are zero
    wire [31:0] ev3_vec = {14'h0000, cnt3_events, 5'h00};
    wire [31:0] ev4_vec = {17'h00000, cnt4_events, 5'h00};

    wire [1:0] amt3 = ev_amount(sel3, ev3_vec, instr_cmpl, instr_disp,
                                tb_rise, `PMES_EV3_MAX,
                                `PMES_EV3_RSVD);
    wire [1:0] amt4 = ev_amount(sel4, ev4_vec, instr_cmpl, instr_disp,
                                tb_rise, `PMES_EV4_MAX,
                                `PMES_EV4_RSVD);

    // ************************************************************
    // Counters
    // ************************************************************

    reg  [31:0] cnt1_r;
    reg  [31:0] cnt2_r;
    reg  [31:0] cnt3_r;
    reg  [31:0] cnt4_r;
    reg  [31:0] sia_r;
    reg         irq_r;

    wire [3:0] ovf = {cnt4_r[`PMES_CNT_TOP], cnt3_r[`PMES_CNT_TOP],
                      cnt2_r[`PMES_CNT_TOP], cnt1_r[`PMES_CNT_TOP]};
    wire       irq_req = global_irq_enable
                         & (|(ovf & counter_irq_control));
    assign pm_irq = irq_req;

    // Counting stops while an interrupt stands and stop is requested
    wire       count_en = ~(stop_on_irq & irq_req);

    wire wr_cnt1 = spr_wr && spr_num == `PMES_SPR_CNT1;
    wire wr_cnt2 = spr_wr && spr_num == `PMES_SPR_CNT2;
    wire wr_cnt3 = spr_wr && spr_num == `PMES_SPR_CNT3;
    wire wr_cnt4 = spr_wr && spr_num == `PMES_SPR_CNT4;
    wire wr_sia  = spr_wr && spr_num == `PMES_SPR_SIA;

    wire [31:0] cnt1_nxt = cnt1_r + {30'h0, cnt1_inc};
    wire [31:0] cnt2_nxt = cnt2_r + {30'h0, cnt2_inc};
    wire [31:0] cnt3_nxt = cnt3_r + {30'h0, amt3};
    wire [31:0] cnt4_nxt = cnt4_r + {30'h0, amt4};

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt1_r <= `PMES_RESET_VAL;
            cnt2_r <= `PMES_RESET_VAL;
            cnt3_r <= `PMES_RESET_VAL;
            cnt4_r <= `PMES_RESET_VAL;
        end else if (ce) begin
            // A software write wins over counting in the same cycle
            if (wr_cnt1)
                cnt1_r <= spr_wdata;
            else if (count_en)
                cnt1_r <= cnt1_nxt;
            if (wr_cnt2)
                cnt2_r <= spr_wdata;
            else if (count_en)
                cnt2_r <= cnt2_nxt;
            if (wr_cnt3)
                cnt3_r <= spr_wdata;
            else if (count_en)
                cnt3_r <= cnt3_nxt;
            if (wr_cnt4)
                cnt4_r <= spr_wdata;
            else if (count_en)
                cnt4_r <= cnt4_nxt;
        end
    end

    // ************************************************************
    // Sampled instruction address
    // ************************************************************

    wire irq_rise = irq_req & ~irq_r;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_r <= 1'b0;
            sia_r <= `PMES_RESET_VAL;
        end else if (ce) begin
            irq_r <= irq_req;
            // Capture on the interrupt's rising edge beats a software write
            if (irq_rise) begin
                if (threshold_event)
                    sia_r <= threshold_iaddr;
                else
                    sia_r <= last_cmpl_iaddr;
            end else if (wr_sia) begin
                sia_r <= spr_wdata;
            end
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************

    reg        map_hit;
    reg [31:0] rd_mux;

    always @* begin
        map_hit = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (spr_num)
            `PMES_SPR_CNT1, `PMES_SPR_UCNT1: rd_mux = cnt1_r;
            `PMES_SPR_CNT2, `PMES_SPR_UCNT2: rd_mux = cnt2_r;
            `PMES_SPR_CNT3, `PMES_SPR_UCNT3: rd_mux = cnt3_r;
            `PMES_SPR_CNT4, `PMES_SPR_UCNT4: rd_mux = cnt4_r;
            `PMES_SPR_SIA, `PMES_SPR_USER_SAMPLED_INSTR_MIRROR:   rd_mux = sia_r;
            `PMES_SPR_SDA, `PMES_SPR_USER_SAMPLED_DATA_UNUSED:   rd_mux = 32'h0000_0000;
            default: map_hit = 1'b0;
        endcase
    end

    // Mapped numbers never raise an exception, unused ones included
    assign spr_hit = map_hit;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spr_rdata  <= 32'h0000_0000;
            spr_rvalid <= 1'b0;
        end else if (ce) begin
            spr_rvalid <= spr_rd;
            if (spr_rd)
                spr_rdata <= rd_mux;
        end
    end

endmodule // pmes_core

// ---- verif/pmes_core_props.sv ----
// Assertion checker for the event select slice
`include "pmes_defines.vh"
module pmes_props (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        spr_wr,
    input wire logic        spr_rd,
    input wire logic        ce,
    input wire logic [9:0]  spr_num,
    input wire logic [31:0] spr_rdata,
    input wire logic        spr_rvalid,
    input wire logic        spr_hit,
    input wire logic [31:0] monitor_control_second,
    input wire logic [3:0]  counter_irq_control,
    input wire logic        global_irq_enable,
    input wire logic        pm_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rd = spr_rd && ce;
    wire s0 = monitor_control_second[31:27] == 5'h00;
    wire [5:0] up = spr_num[9:4];
    wire [3:0] lo = spr_num[3:0];
    rvalid_after_rd_a: assert property (rd |=> spr_rvalid)
        else $error("read not answered");
    // A frozen clock enable keeps the last answer standing
    rvalid_cause_a: assert property (spr_rvalid |-> $past(rd) || $past(!ce))
        else $error("answer without read");
    rdata_hold_a: assert property (!rd |=> $stable(spr_rdata))
        else $error("read data moved");
    number_map_a: assert property (spr_hit == ((up == 6'h3A ||
        up == 6'h3B) && lo >= 4'h9 && lo != 4'hC))
        else $error("mapped number flag wrong");
    unused_zero_a: assert property (rd && (spr_num == `PMES_SPR_SDA ||
        spr_num == `PMES_SPR_USER_SAMPLED_DATA_UNUSED) |=> spr_rdata == 32'h0000_0000)
        else $error("unused register not zero");
    irq_global_a: assert property (pm_irq |-> global_irq_enable)
        else $error("interrupt without global enable");
    irq_control_a: assert property (pm_irq |-> counter_irq_control != 4'h0)
        else $error("interrupt without counter enable");
    mirror_same_a: assert property ((rd && !spr_wr && s0 &&
        spr_num == `PMES_SPR_CNT3) ##1 (!spr_wr && !spr_rd && ce && s0) ##1
        (rd && spr_num == `PMES_SPR_UCNT3) |=> spr_rdata == $past(spr_rdata))
        else $error("mirror differs from counter");
    cover property (rd);
    cover property ($rose(pm_irq));
    cover property (spr_wr && spr_hit);
endmodule // pmes_props

bind pmes_core pmes_props u_props (.clk, .resetn, .spr_wr, .spr_rd, .ce,
    .spr_num, .spr_rdata, .spr_rvalid, .spr_hit, .monitor_control_second,
    .counter_irq_control, .global_irq_enable, .pm_irq);

// ---- verif/pmes_testbench.sv ----
// Self-checking bench for the event select slice
`include "pmes_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, resetn = 0, ce = 1, spr_wr = 0, spr_rd = 0;
    logic        global_irq_enable = 0, stop_on_irq = 0, instr_cmpl = 1;
    logic        threshold_event = 1, spr_rvalid, spr_hit, pm_irq;
    logic [9:0]  spr_num = 10'h000;
    logic [31:0] spr_wdata = 32'h0, spr_rdata, monitor_control_second = 32'h0;
    logic [31:0] timebase_lower = 32'h0, threshold_iaddr = 32'h0000_1234;
    logic [31:0] last_cmpl_iaddr = 32'h0000_5678, rd_v;
    logic [1:0]  timebase_bit_select = 2'h0, instr_disp = 2'h2;
    logic [1:0]  cnt1_inc = 2'h0, cnt2_inc = 2'h0;
    logic [3:0]  counter_irq_control = 4'h0;
    logic [17:5] cnt3_events = 13'h0;
    logic [14:5] cnt4_events = 10'h0;
    int          fail_count = 0, tests_run = 0, cyc = 0;

    pmes_core uut (.clk, .resetn, .ce, .spr_wr, .spr_rd, .spr_num, .spr_wdata,
        .spr_rdata, .spr_rvalid, .spr_hit, .monitor_control_second,
        .timebase_bit_select, .counter_irq_control, .global_irq_enable,
        .stop_on_irq, .cnt1_inc, .cnt2_inc, .instr_cmpl, .instr_disp,
        .timebase_lower, .cnt3_events, .cnt4_events, .threshold_event,
        .threshold_iaddr, .last_cmpl_iaddr, .pm_irq);

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end

    // ************************************************************
    // Bus tasks and scenarios
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic spr_write(input logic [9:0] n, input logic [31:0] d);
        @(negedge clk);
        spr_num = n;
        spr_wdata = d;
        spr_wr = 1;
        @(negedge clk);
        spr_wr = 0;
    endtask
    task automatic spr_read(input logic [9:0] n);
        @(negedge clk);
        spr_num = n;
        spr_rd = 1;
        @(negedge clk);
        spr_rd = 0;
        check({31'h0, spr_rvalid}, 32'h1);
        rd_v = spr_rdata;
    endtask
    task automatic rd_chk(input logic [9:0] n, input logic [31:0] e);
        spr_read(n);
        check(rd_v, e);
    endtask
    task automatic run_code(input bit four, input logic [4:0] c,
                            input logic [1:0] s);
        logic [31:0] e;
        logic [31:0] m;
        e = (c == 1 || c == 2) ? 4 : (c == 3) ? 2 : (c == 4) ? 8 :
            (c >= 5 && c <= (four ? 14 : 17) && c != (four ? 7 : 14)) ? 4 : 0;
        m = 32'h1 << ((s == 3) ? 0 : 16 - 4 * s);
        timebase_bit_select = s;
        timebase_lower = 32'h0;
        cnt3_events = (c >= 5) ? 13'h1 << (c - 5) : 13'h0;
        cnt4_events = (c >= 5) ? 10'h1 << (c - 5) : 10'h0;
        monitor_control_second = four ? {5'h0, c, 22'h0} : {c, 27'h0};
        spr_write(four ? `PMES_SPR_CNT4 : `PMES_SPR_CNT3, 32'h0);
        for (int i = 0; i < 4; i++) begin
            timebase_lower = i[0] ? m : 32'h0;
            @(negedge clk);
        end
        monitor_control_second = 32'h0;
        rd_chk(four ? `PMES_SPR_CNT4 : `PMES_SPR_CNT3, e);
    endtask
    task automatic s_regs();
        spr_write(`PMES_SPR_CNT1, 32'h1111_0001);
        spr_write(`PMES_SPR_UCNT1, 32'hFFFF_FFFF);
        rd_chk(`PMES_SPR_UCNT1, 32'h1111_0001);
        spr_write(`PMES_SPR_CNT2, 32'h2222_0002);
        rd_chk(`PMES_SPR_UCNT2, 32'h2222_0002);
        spr_write(`PMES_SPR_CNT3, 32'h3333_0003);
        rd_chk(`PMES_SPR_CNT3, 32'h3333_0003);
        rd_chk(`PMES_SPR_UCNT3, 32'h3333_0003);
        spr_write(`PMES_SPR_CNT4, 32'h4444_0004);
        rd_chk(`PMES_SPR_UCNT4, 32'h4444_0004);
        spr_write(`PMES_SPR_SDA, 32'hFFFF_FFFF);
        spr_write(`PMES_SPR_USER_SAMPLED_DATA_UNUSED, 32'hFFFF_FFFF);
        check({31'h0, spr_hit}, 32'h1);
        rd_chk(`PMES_SPR_SDA, 32'h0);
        rd_chk(`PMES_SPR_USER_SAMPLED_DATA_UNUSED, 32'h0);
        spr_num = 10'h3AC;
        #1 check({31'h0, spr_hit}, 32'h0);
    endtask
    // Clock enable low freezes counting and writes; then a reset in mid-run
    task automatic s_ce();
        monitor_control_second = {5'h01, 27'h0};
        spr_write(`PMES_SPR_CNT3, 32'h0000_0010);
        ce = 0;
        spr_write(`PMES_SPR_CNT3, 32'h0000_FFFF);
        repeat (3) @(negedge clk);
        ce = 1;
        monitor_control_second = 32'h0;
        rd_chk(`PMES_SPR_CNT3, 32'h0000_0010);
        resetn = 0;
        @(negedge clk);
        resetn = 1;
        rd_chk(`PMES_SPR_CNT3, `PMES_RESET_VAL);
    endtask
    task automatic s_irq();
        monitor_control_second = {5'h01, 27'h0};
        counter_irq_control = 4'h4;
        global_irq_enable = 1;
        stop_on_irq = 1;
        spr_write(`PMES_SPR_CNT3, 32'h7FFF_FFFE);
        repeat (6) @(negedge clk);
        check({31'h0, pm_irq}, 32'h1);
        rd_chk(`PMES_SPR_CNT3, 32'h8000_0000);
        rd_chk(`PMES_SPR_SIA, 32'h0000_1234);
        rd_chk(`PMES_SPR_USER_SAMPLED_INSTR_MIRROR, 32'h0000_1234);
        counter_irq_control = 4'h8;
        #1 check({31'h0, pm_irq}, 32'h0);
        counter_irq_control = 4'h4;
        threshold_event = 0;
        spr_write(`PMES_SPR_CNT3, 32'h0);
        spr_write(`PMES_SPR_CNT3, 32'h8000_0000);
        rd_chk(`PMES_SPR_SIA, 32'h0000_5678);
        global_irq_enable = 0;
        #1 check({31'h0, pm_irq}, 32'h0);
    endtask

    initial begin
        repeat (5) @(negedge clk);
        resetn = 1;
        s_regs();
        for (int c = 0; c < 32; c++) begin
            run_code(0, c[4:0], c[1:0]);
            run_code(1, c[4:0], c[1:0]);
        end
        for (int s = 0; s < 4; s++)
            run_code(0, 5'h03, s[1:0]);
        s_irq();
        s_ce();
        report_and_stop();
    end
endmodule // testbench
